// [logic/rsde_engine.sv]
// Receive split descriptor engine: write-back fields, fetch and packing
`timescale 1ns/1ps
module rsde_engine (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Packet from the receive parser
  input  wire logic        pkt_valid,
  input  wire logic        pkt_null_addr,
  input  wire logic [3:0]  pkt_type,
  input  wire logic        pkt_v4_frag,
  input  wire logic        pkt_v6_frag_ext,
  input  wire logic [9:0]  pkt_l3_end,
  input  wire logic [9:0]  pkt_l4_end,
  input  wire logic [9:0]  pkt_l5_end,
  input  wire logic [9:0]  pkt_frag_hdr_end,
  input  wire logic [15:0] pkt_len,
  output logic             pkt_ready,
  // Descriptor write-back fields
  output logic             res_valid,
  output logic             res_done_only,
  output logic [15:0]      res_len0,
  output logic [15:0]      res_len1,
  output logic [15:0]      res_len2,
  output logic [15:0]      res_len3,
  output logic [15:0]      res_hdr_status,
  output logic [3:0]       res_pkt_type,
  // Bus master requests
  input  wire logic        hi_prio_pending,
  output logic             fetch_req,
  output logic [15:0]      fetch_index,
  output logic [7:0]       fetch_count,
  input  wire logic        fetch_done,
  output logic             wb_req,
  output logic [15:0]      wb_index,
  output logic [7:0]       wb_count,
  input  wire logic        wb_done,
  // Receive timers and head
  input  wire logic        timer_expired,
  output logic             rx_irq,
  output logic [15:0]      head
);
  import rsde_pkg::*;

  // Buffer size in bytes, field in 128-byte units
  function automatic logic [15:0] buf_bytes(input logic [31:0] bs, input int i);
    buf_bytes = {1'b0, bs[8*i +: 8], 7'h00};
  endfunction

  // Descriptor ring distance, wrapping at ring length
  function automatic logic [15:0] ring_dist(input logic [15:0] from, input logic [15:0] to,
                                            input logic [15:0] len);
    if (to >= from) begin
      ring_dist = to - from;
    end else begin
      ring_dist = len - from + to;
    end
  endfunction

  // Software registers
  logic [31:0] ctrl;          // Format and offload control
  logic [31:0] bsize;         // Four buffer sizes
  logic [31:0] thresh;        // Prefetch, host and write-back thresholds
  logic [15:0] ring_len;      // Ring length in descriptors
  logic [15:0] tail;          // Tail in 16-byte blocks
  logic [15:0] pdt;           // Packet delay value, kept for readback
  logic [31:0] next_ctrl, next_bsize, next_thresh, next_rdata;
  logic [15:0] next_ring_len, next_tail, next_pdt;
  logic        sw_flush;      // Flush bit written this cycle

  // Engine state
  rsde_bus_e   bus, next_bus;
  logic [7:0]  onchip, next_onchip;   // Descriptors held on chip
  logic [7:0]  used, next_used;       // Used, not yet written back
  logic [15:0] fptr, next_fptr;       // Next descriptor to fetch
  logic [15:0] next_head;
  logic        flush_pend, next_flush_pend;
  logic        irq_pend, next_irq_pend;
  logic        next_fetch_req, next_wb_req, next_irq, next_ready;
  logic [15:0] next_fetch_index, next_wb_index;
  logic [7:0]  next_fetch_count, next_wb_count;

  // Result fields
  logic        next_res_valid, next_done_only;
  logic [15:0] next_len [4];
  logic [15:0] next_hs;
  logic [3:0]  next_ptype;

  wire split_mode = ctrl[CTRL_EXT_STATUS] &&
                    (ctrl[CTRL_DTYPE_LO +: 2] == DTYPE_SPLIT);
  wire parse_en   = ctrl[CTRL_PARSE_EN];
  wire consume    = pkt_valid && pkt_ready;

  // Register write decode and read mux
  always_comb begin
    next_ctrl     = ctrl;
    next_bsize    = bsize;
    next_thresh   = thresh;
    next_ring_len = ring_len;
    next_tail     = tail;
    next_pdt      = pdt;
    sw_flush      = 1'b0;
    next_rdata    = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL:   next_ctrl     = reg_wdata;
        ADDR_BSIZE:  next_bsize    = reg_wdata;
        ADDR_THRESH: next_thresh   = reg_wdata;
        ADDR_RLEN:   next_ring_len = reg_wdata[15:0];
        ADDR_TAIL:   next_tail     = reg_wdata[15:0];
        ADDR_PDT: begin
          next_pdt = reg_wdata[15:0];
          sw_flush = reg_wdata[PDT_FLUSH_BIT];
        end
        default: next_ctrl = ctrl;   // Unmapped writes ignored
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL:   next_rdata = ctrl;
        ADDR_BSIZE:  next_rdata = bsize;
        ADDR_THRESH: next_rdata = thresh;
        ADDR_RLEN:   next_rdata = {16'h0000, ring_len};
        ADDR_TAIL:   next_rdata = {16'h0000, tail};
        ADDR_PDT:    next_rdata = {16'h0000, pdt};
        ADDR_HEAD:   next_rdata = {16'h0000, head};
        ADDR_STAT:   next_rdata = {fptr, used, onchip};
        default:     next_rdata = 32'h0000_0000;   // Unmapped reads zero
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl      <= CTRL_RST;
      bsize     <= BSIZE_RST;
      thresh    <= THRESH_RST;
      ring_len  <= 16'h0000;
      tail      <= 16'h0000;
      pdt       <= 16'h0000;
      reg_rdata <= 32'h0000_0000;
    end else begin
      ctrl      <= next_ctrl;
      bsize     <= next_bsize;
      thresh    <= next_thresh;
      ring_len  <= next_ring_len;
      tail      <= next_tail;
      pdt       <= next_pdt;
      reg_rdata <= next_rdata;
    end
  end

  // Split decision and buffer lengths for one packet
  always_comb begin
    logic        do_split;
    logic [9:0]  header_byte_count;
    logic [15:0] stored, rem, take, cap;
    do_split = 1'b0;
    header_byte_count     = 10'h000;
    stored   = 16'h0000;
    rem      = 16'h0000;
    take     = 16'h0000;
    cap      = 16'h0000;
    // Frame check bytes count when they stay in memory
    stored = ctrl[CTRL_CRC_STRIP] ? pkt_len : pkt_len + CRC_BYTES;
    case (pkt_type)
      PT_V4: begin
        do_split = pkt_v4_frag;
        header_byte_count     = pkt_l3_end;
      end
      PT_V4_L4, PT_V4_ISC, PT_V4_NFS: begin
        do_split = 1'b1;
        if (pkt_v4_frag) begin
          header_byte_count = pkt_l3_end;
        end else begin
          header_byte_count = (pkt_type == PT_V4_L4) ? pkt_l4_end : pkt_l5_end;
        end
      end
      PT_46: begin
        do_split = pkt_v4_frag || pkt_v6_frag_ext;
        header_byte_count     = pkt_v6_frag_ext ? pkt_frag_hdr_end : pkt_l3_end;
      end
      PT_46_L4, PT_46_ISC, PT_46_NFS: begin
        do_split = 1'b1;
        if (pkt_v6_frag_ext) begin
          header_byte_count = pkt_frag_hdr_end;
        end else if (pkt_v4_frag) begin
          header_byte_count = pkt_l3_end;
        end else begin
          header_byte_count = (pkt_type == PT_46_L4) ? pkt_l4_end : pkt_l5_end;
        end
      end
      PT_V6: begin
        do_split = pkt_v6_frag_ext;
        header_byte_count     = pkt_frag_hdr_end;
      end
      PT_V6_L4, PT_V6_ISC, PT_V6_NFS: begin
        do_split = 1'b1;
        if (pkt_v6_frag_ext) begin
          header_byte_count = pkt_frag_hdr_end;
        end else begin
          header_byte_count = (pkt_type == PT_V6_L4) ? pkt_l4_end : pkt_l5_end;
        end
      end
      default: do_split = 1'b0;   // Types 0x0, 0xD, 0xE: no split
    endcase
    // Offload off or non-split format: never split
    if (!parse_en || !split_mode) begin
      do_split = 1'b0;
    end
    // Short data tail not worth a split; header must fit buffer zero
    if ({6'h00, header_byte_count} > stored || stored - {6'h00, header_byte_count} < SMALL_DATA ||
        {6'h00, header_byte_count} > buf_bytes(bsize, 0)) begin
      do_split = 1'b0;
    end
    rem = do_split ? stored - {6'h00, header_byte_count} : stored;
    // Fill buffers in order; untouched buffers report zero
    for (int i = 0; i < 4; i++) begin
      cap = buf_bytes(bsize, i);
      if (do_split && i == 0) begin
        take = {6'h00, header_byte_count};
      end else begin
        take = (rem < cap) ? rem : cap;
        rem  = rem - take;
      end
      next_len[i] = (pkt_null_addr && !split_mode) ? 16'h0000 : take;
    end
    // Header status: flag, reserved zeros, byte count
    next_hs = {do_split, 5'h00, do_split ? header_byte_count : 10'h000};
    next_ptype     = parse_en ? pkt_type : PT_L2;
    next_res_valid = consume;
    // Null padding only for non-split formats
    next_done_only = consume && pkt_null_addr && !split_mode;
  end

  // Result registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      res_valid      <= 1'b0;
      res_done_only  <= 1'b0;
      res_len0       <= 16'h0000;
      res_len1       <= 16'h0000;
      res_len2       <= 16'h0000;
      res_len3       <= 16'h0000;
      res_hdr_status <= 16'h0000;
      res_pkt_type   <= 4'h0;
    end else begin
      res_valid      <= next_res_valid;
      res_done_only  <= next_done_only;
      res_len0       <= next_len[0];
      res_len1       <= next_len[1];
      res_len2       <= next_len[2];
      res_len3       <= next_len[3];
      res_hdr_status <= next_hs;
      res_pkt_type   <= next_ptype;
    end
  end

  // Fetch and write-back sequencer
  always_comb begin
    logic [15:0] tail_d, avail, cnt, free, misal, to_end;
    logic [7:0]  used_n, onchip_n, wth, cnt8;
    logic        wb_force, ring_end;
    tail_d   = split_mode ? {1'b0, tail[15:1]} : tail;
    avail    = ring_dist(fptr, tail_d, ring_len);
    free     = {8'h00, ONCHIP_MAX - onchip};
    misal    = 16'h0000;
    cnt      = 16'h0000;
    to_end   = ring_len - fptr;
    used_n   = used;
    onchip_n = onchip;
    wth      = {2'b00, thresh[TH_WBACK +: 6]};
    cnt8     = 8'h00;
    wb_force = 1'b0;
    ring_end = 1'b0;
    next_bus         = bus;
    next_fptr        = fptr;
    next_head        = head;
    next_fetch_req   = 1'b0;
    next_wb_req      = 1'b0;
    next_fetch_index = fetch_index;
    next_fetch_count = fetch_count;
    next_wb_index    = wb_index;
    next_wb_count    = wb_count;
    next_irq         = 1'b0;
    next_flush_pend  = flush_pend;
    next_irq_pend    = irq_pend;
    // Packet use moves a descriptor from store to used list
    if (consume) begin
      onchip_n = onchip_n - 8'h01;
      used_n   = used_n + 8'h01;
    end
    case (bus)
      RSDE_FETCH: begin
        if (fetch_done) begin
          onchip_n  = onchip_n + fetch_count;
          next_fptr = (fptr + {8'h00, fetch_count} >= ring_len) ?
                      fptr + {8'h00, fetch_count} - ring_len : fptr + {8'h00, fetch_count};
          next_bus  = RSDE_IDLE;
        end
      end
      RSDE_WBACK: begin
        if (wb_done) begin
          used_n    = used_n - wb_count;
          // Head moves only once the write-back landed
          next_head = (head + {8'h00, wb_count} >= ring_len) ?
                      head + {8'h00, wb_count} - ring_len : head + {8'h00, wb_count};
          next_bus  = RSDE_IDLE;
        end
      end
      RSDE_IDLE: begin
        ring_end = (head + {8'h00, used} >= ring_len) && (ring_len != 16'h0000);
        wb_force = flush_pend || ring_end || (wth != 8'h00 && used >= wth);
        if (used != 8'h00 && (wb_force || used >= CLINE_DESC)) begin
          // Full line normally; everything when forced
          next_wb_count = wb_force ? used : CLINE_DESC;
          next_wb_index = head;
          next_wb_req   = 1'b1;
          next_bus      = RSDE_WBACK;
        end else if (flush_pend) begin
          // Nothing left to write: release the interrupt now
          next_flush_pend = 1'b0;
          next_irq        = irq_pend;
          next_irq_pend   = 1'b0;
        end else if (avail != 16'h0000 && free != 16'h0000 &&
                     ((onchip == 8'h00) ||
                      (onchip <= {2'b00, thresh[TH_PREFETCH +: 6]} &&
                       avail >= {10'h000, thresh[TH_HOSTAV +: 6]} &&
                       !hi_prio_pending))) begin
          // Never past the tail, never past free space
          cnt = (avail < free) ? avail : free;
          if (avail > free) begin
            misal = (fptr + free) & {8'h00, CLINE_MASK};
            if (free > misal) begin
              cnt = free - misal;
            end
          end
          // Stop at ring end so the next fetch starts at base
          if (cnt > to_end) begin
            cnt = to_end;
          end
          cnt8             = cnt[7:0];
          next_fetch_count = cnt8;
          next_fetch_index = fptr;
          next_fetch_req   = 1'b1;
          // One sequencer keeps fetch behind any write-back
          next_bus         = RSDE_FETCH;
        end
      end
      default: next_bus = RSDE_IDLE;
    endcase
    // New flush causes win over the clear above
    if (timer_expired || sw_flush) begin
      next_flush_pend = 1'b1;
    end
    if (timer_expired) begin
      next_irq_pend = 1'b1;
    end
    next_onchip = onchip_n;
    next_used   = used_n;
    next_ready  = onchip_n != 8'h00;
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus         <= RSDE_IDLE;
      onchip      <= 8'h00;
      used        <= 8'h00;
      fptr        <= 16'h0000;
      head        <= 16'h0000;
      flush_pend  <= 1'b0;
      irq_pend    <= 1'b0;
      fetch_req   <= 1'b0;
      fetch_index <= 16'h0000;
      fetch_count <= 8'h00;
      wb_req      <= 1'b0;
      wb_index    <= 16'h0000;
      wb_count    <= 8'h00;
      rx_irq      <= 1'b0;
      pkt_ready   <= 1'b0;
    end else begin
      bus         <= next_bus;
      onchip      <= next_onchip;
      used        <= next_used;
      fptr        <= next_fptr;
      head        <= next_head;
      flush_pend  <= next_flush_pend;
      irq_pend    <= next_irq_pend;
      fetch_req   <= next_fetch_req;
      fetch_index <= next_fetch_index;
      fetch_count <= next_fetch_count;
      wb_req      <= next_wb_req;
      wb_index    <= next_wb_index;
      wb_count    <= next_wb_count;
      rx_irq      <= next_irq;
      pkt_ready   <= next_ready;
    end
  end
endmodule

// [logic/rsde_pkg.sv]
// Constants and register map of the receive split descriptor engine
// Functional notes
// - Write byte count per buffer, zero if unused
// - Lengths include kept frame check bytes
// - Length 0 at 8.32, lengths 1-3 at 16.16
// - Header status: split flag, reserved, byte count
// - Small data portions may skip splitting
// - No parsing offload: no split, type zero
// - Split mode always reports valid packet type; here type zero if parsing off
// - Split puts exactly header bytes in buffer zero
// - IPv4/IPv6 plain split after L3 if fragmented
// - IPv4 L4/L5 types split, fragmented as 0x1
// - IPv4-in-IPv6 L4/L5 types split, fragmented as 0x3
// - IPv6 L4/L5 types split, fragmented as 0x5
// - Types 0x0, 0xE never split; sequential fill
// - Fragmented IPv6 header ends at fragment header
// - Empty store fetches on any tail advance
// - Prefetch needs occupancy, availability, idle bus
// - Oversized backlog fetch realigns next fetch
// - Never fetch at or beyond tail
// - Write back in chunks, or forced triggers
// - Threshold reached writes back regardless of alignment
// - Timer expiry flushes before interrupt; flush bit
// - Null non-split descriptors: done bit only
// - Write back completes before head advances
package rsde_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_BSIZE  = 8'h04;
  localparam logic [7:0] ADDR_THRESH = 8'h08;
  localparam logic [7:0] ADDR_RLEN   = 8'h0C;
  localparam logic [7:0] ADDR_TAIL   = 8'h10;
  localparam logic [7:0] ADDR_PDT    = 8'h14;
  localparam logic [7:0] ADDR_HEAD   = 8'h18;
  localparam logic [7:0] ADDR_STAT   = 8'h1C;
  // Control field positions
  localparam int CTRL_EXT_STATUS = 0;
  localparam int CTRL_DTYPE_LO   = 1;
  localparam int CTRL_PARSE_EN   = 3;
  localparam int CTRL_CRC_STRIP  = 4;
  localparam logic [1:0] DTYPE_SPLIT = 2'h1;
  localparam int PDT_FLUSH_BIT   = 31;
  // Threshold field positions
  localparam int TH_PREFETCH = 0;
  localparam int TH_HOSTAV   = 8;
  localparam int TH_WBACK    = 16;
  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] BSIZE_RST  = 32'h0000_0000;
  localparam logic [31:0] THRESH_RST = 32'h0000_0000;
  // Sizes: on-chip store and cache line in descriptors
  localparam logic [7:0] ONCHIP_MAX = 8'h10;
  localparam logic [7:0] CLINE_DESC = 8'h04;
  localparam logic [7:0] CLINE_MASK = 8'h03;
  localparam logic [15:0] CRC_BYTES = 16'h0004;
  localparam logic [15:0] SMALL_DATA = 16'h0010;
  // Header status layout
  localparam int HS_SPLIT = 15;
  // Packet type codes
  localparam logic [3:0] PT_L2      = 4'h0;
  localparam logic [3:0] PT_V4      = 4'h1;
  localparam logic [3:0] PT_V4_L4   = 4'h2;
  localparam logic [3:0] PT_46      = 4'h3;
  localparam logic [3:0] PT_46_L4   = 4'h4;
  localparam logic [3:0] PT_V6      = 4'h5;
  localparam logic [3:0] PT_V6_L4   = 4'h6;
  localparam logic [3:0] PT_V4_ISC  = 4'h7;
  localparam logic [3:0] PT_V4_NFS  = 4'h8;
  localparam logic [3:0] PT_46_ISC  = 4'h9;
  localparam logic [3:0] PT_46_NFS  = 4'hA;
  localparam logic [3:0] PT_V6_ISC  = 4'hB;
  localparam logic [3:0] PT_V6_NFS  = 4'hC;
  // Bus sequencer states, Gray along idle-fetch-writeback
  typedef enum logic [1:0] {
    RSDE_IDLE  = 2'h0,
    RSDE_FETCH = 2'h1,
    RSDE_WBACK = 2'h3
  } rsde_bus_e;
endpackage

// [tb/rsde_chk.sv]
// Port checker of the receive split descriptor engine
`timescale 1ns/1ps
module rsde_chk
  import rsde_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Packet side
  input wire logic        pkt_valid,
  input wire logic        pkt_ready,
  input wire logic        res_valid,
  input wire logic        res_done_only,
  input wire logic [15:0] res_len0,
  input wire logic [15:0] res_len1,
  input wire logic [15:0] res_len2,
  input wire logic [15:0] res_len3,
  input wire logic [15:0] res_hdr_status,
  // Bus side
  input wire logic        fetch_req,
  input wire logic [7:0]  fetch_count,
  input wire logic        wb_req,
  input wire logic        wb_done,
  input wire logic [15:0] head
);
  // One clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_res_answer: assert property (pkt_valid && pkt_ready |=> res_valid)
    else $error("taken packet gave no result");
  chk_res_refused: assert property (!(pkt_valid && pkt_ready) |=> !res_valid)
    else $error("result without a taken packet");
  chk_hdr_rsvd: assert property (res_valid |-> res_hdr_status[14:10] == 5'h00)
    else $error("reserved header status bits set");
  chk_split_len0: assert property (res_valid && res_hdr_status[15]
    |-> res_len0 == {6'h00, res_hdr_status[9:0]})
    else $error("buffer zero length not header count");
  chk_pad_lens: assert property (res_valid && res_done_only
    |-> (res_len0 | res_len1 | res_len2 | res_len3) == 16'h0000)
    else $error("null descriptor reported data");
  chk_fetch_alone: assert property (fetch_req |-> !wb_req ##1 !fetch_req && !wb_req)
    else $error("bus overlap after fetch");
  chk_wb_alone: assert property (wb_req |=> !wb_req && !fetch_req)
    else $error("bus overlap after write-back");
  chk_fetch_size: assert property (fetch_req
    |-> fetch_count != 8'h00 && fetch_count <= ONCHIP_MAX)
    else $error("fetch count outside on-chip space");
  chk_head_move: assert property ($changed(head) |-> $past(wb_done))
    else $error("head moved before write-back done");
endmodule
bind rsde_engine rsde_chk chk_u (.clk(clk), .reset_n(reset_n), .pkt_valid(pkt_valid),
  .pkt_ready(pkt_ready), .res_valid(res_valid), .res_done_only(res_done_only),
  .res_len0(res_len0), .res_len1(res_len1), .res_len2(res_len2), .res_len3(res_len3),
  .res_hdr_status(res_hdr_status), .fetch_req(fetch_req), .fetch_count(fetch_count),
  .wb_req(wb_req), .wb_done(wb_done), .head(head));

// [tb/rsde_host.sv]
// Host memory model answering descriptor fetches and write-backs
`timescale 1ns/1ps
module rsde_host (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Answer delay mode
  input wire logic slow,
  // Bus requests and completions
  input wire logic fetch_req,
  input wire logic wb_req,
  output logic     fetch_done,
  output logic     wb_done
);
  bit is_fetch; // Request kind in flight
  initial {fetch_done, wb_done} = 2'b00;
  // One request at a time; slow mode stalls
  always @(posedge clk) begin
    if (reset_n && (fetch_req || wb_req)) begin
      is_fetch = fetch_req;
      repeat (slow ? $urandom_range(1, 8) : 0) @(posedge clk);
      if (is_fetch) fetch_done <= 1'b1;
      else wb_done <= 1'b1;
      @(posedge clk);
      {fetch_done, wb_done} <= 2'b00;
    end
  end
endmodule

// [tb/rsde_engine_tb_top.sv]
// Self-checking bench of the receive split descriptor engine
`timescale 1ns/1ps
module rsde_engine_tb_top;
  import rsde_pkg::*;
  logic        clk, reset_n, reg_wr, reg_rd, pkt_valid, pkt_null_addr, pkt_v4_frag;
  logic        pkt_v6_frag_ext, hi_prio_pending, fetch_done, wb_done, timer_expired;
  logic        pkt_ready, res_valid, res_done_only, fetch_req, wb_req, rx_irq, slow;
  logic [7:0]  reg_addr, fetch_count, wb_count;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0]  pkt_type, res_pkt_type;
  logic [9:0]  pkt_l3_end, pkt_l4_end, pkt_l5_end, pkt_frag_hdr_end;
  logic [15:0] pkt_len, res_len0, res_len1, res_len2, res_len3, res_hdr_status;
  logic [15:0] fetch_index, wb_index, head;
  int          num_errors, compares, cyc, fptr, lim, used, hd, i;
  bit          parse, split_m, strip, irq_seen;
  rsde_engine dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pkt_valid(pkt_valid), .pkt_null_addr(pkt_null_addr), .pkt_type(pkt_type),
    .pkt_v4_frag(pkt_v4_frag), .pkt_v6_frag_ext(pkt_v6_frag_ext), .pkt_l3_end(pkt_l3_end),
    .pkt_l4_end(pkt_l4_end), .pkt_l5_end(pkt_l5_end), .pkt_frag_hdr_end(pkt_frag_hdr_end),
    .pkt_len(pkt_len), .pkt_ready(pkt_ready), .res_valid(res_valid),
    .res_done_only(res_done_only), .res_len0(res_len0), .res_len1(res_len1),
    .res_len2(res_len2), .res_len3(res_len3), .res_hdr_status(res_hdr_status),
    .res_pkt_type(res_pkt_type), .hi_prio_pending(hi_prio_pending), .fetch_req(fetch_req),
    .fetch_index(fetch_index), .fetch_count(fetch_count), .fetch_done(fetch_done),
    .wb_req(wb_req), .wb_index(wb_index), .wb_count(wb_count), .wb_done(wb_done),
    .timer_expired(timer_expired), .rx_irq(rx_irq), .head(head));
  rsde_host host_u (.clk(clk), .reset_n(reset_n), .slow(slow), .fetch_req(fetch_req),
    .wb_req(wb_req), .fetch_done(fetch_done), .wb_done(wb_done));
  // Verdict, the only exit
  task automatic wrap_up();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Shared compare
  task automatic chk(input bit ok, input string m);
    compares++;
    if (!ok) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // Register bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk((reg_rdata & m) === e, "register read");
  endtask
  // Bounded wait for all write-backs
  task automatic drain();
    for (i = 0; i < 80 && (used != 0 || head !== 16'(hd)); i++) @(negedge clk);
    chk(used == 0, "write-back not forced");
  endtask
  // One packet against the reference model
  task automatic pkt(input bit nul);
    int t, l3, l4, l5, fh, h, ln, rem, b;
    int e[4] = '{0, 0, 0, 0};
    int c[4] = '{256, 512, 512, 512};
    bit f4, f6, pad;
    t = $urandom_range(0, 13);
    t = (t == 13) ? 14 : t;
    f4 = $urandom_range(0, 1);
    f6 = $urandom_range(0, 1);
    l3 = $urandom_range(34, 60);
    l4 = l3 + 20;
    l5 = l4 + $urandom_range(8, 40);
    fh = l3 + 8;
    case (t)
      1: h = f4 ? l3 : 0;
      2, 7, 8: h = f4 ? l3 : (t == 2 ? l4 : l5);
      3: h = f6 ? fh : (f4 ? l3 : 0);
      4, 9, 10: h = f6 ? fh : (f4 ? l3 : (t == 4 ? l4 : l5));
      5: h = f6 ? fh : 0;
      6, 11, 12: h = f6 ? fh : (t == 6 ? l4 : l5);
      default: h = 0;
    endcase
    ln = (strip && $urandom_range(0, 3) == 0) ? h + $urandom_range(0, 15)
      : l5 + $urandom_range(16, 1300);
    if (!parse || !split_m || ln - h < 16) h = 0;
    pad = nul && !split_m;
    rem = ln + (strip ? 0 : 4);
    e[0] = h;
    rem -= h;
    for (b = int'(h > 0); b < 4; b++) begin
      e[b] = pad ? 0 : (rem < c[b] ? rem : c[b]);
      rem -= e[b];
    end
    for (b = 0; b < 200 && pkt_ready !== 1'b1; b++) @(negedge clk);
    chk(pkt_ready === 1'b1, "no descriptor on chip");
    @(posedge clk);
    pkt_valid <= 1'b1;
    pkt_null_addr <= nul;
    pkt_type <= 4'(t);
    pkt_v4_frag <= f4;
    pkt_v6_frag_ext <= f6;
    pkt_l3_end <= 10'(l3);
    pkt_l4_end <= 10'(l4);
    pkt_l5_end <= 10'(l5);
    pkt_frag_hdr_end <= 10'(fh);
    pkt_len <= 16'(ln);
    @(posedge clk);
    pkt_valid <= 1'b0;
    used++;
    @(negedge clk);
    chk(res_valid === 1'b1 && res_done_only === pad, "result or padding");
    if (!pad) chk({res_len0, res_len1, res_len2, res_len3} === {16'(e[0]), 16'(e[1]),
      16'(e[2]), 16'(e[3])}, "buffer lengths");
    if (!pad) chk(res_hdr_status === {h > 0, 5'h00, 10'(h)}, "header status");
    if (!pad) chk(res_pkt_type === (parse ? 4'(t) : 4'h0), "packet type");
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Competing bus traffic at random
  always @(posedge clk) hi_prio_pending <= 1'($urandom_range(0, 1));
  // Bus monitor and timeout
  always @(negedge clk) begin
    cyc++;
    if (cyc > 30000) begin
      chk(1'b0, "timeout");
      wrap_up();
    end
    if (fetch_req === 1'b1) begin
      chk(fetch_index === 16'(fptr) && fptr + fetch_count <= lim, "fetch past tail");
      fptr += fetch_count;
    end
    if (wb_req === 1'b1) begin
      chk(wb_index === 16'(hd) && wb_count != 0 && wb_count <= used
        && (wb_count == 4 || wb_count == used), "write-back count");
      used -= wb_count;
      hd += wb_count;
    end
    if (rx_irq === 1'b1) begin
      irq_seen = 1;
      chk(used == 0, "interrupt before write-back");
    end
  end
  // Main sequence
  initial begin
    {reset_n, reg_wr, reg_rd, pkt_valid, pkt_null_addr, pkt_v4_frag, pkt_v6_frag_ext} = '0;
    {timer_expired, slow, reg_addr, reg_wdata, pkt_type, pkt_l3_end, pkt_l4_end} = '0;
    {pkt_l5_end, pkt_frag_hdr_end, pkt_len} = '0;
    void'($urandom(32'hedcc142e));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values, unmapped read
    rd(ADDR_CTRL, 32'hFFFFFFFF, CTRL_RST);
    rd(ADDR_THRESH, 32'hFFFFFFFF, THRESH_RST);
    rd(8'hFC, 32'hFFFFFFFF, 32'h00000000);
    // Split format, parsing, 256/512 byte buffers
    wr(ADDR_CTRL, 32'h0000001B);
    {parse, split_m, strip} = 3'b111;
    wr(ADDR_BSIZE, 32'h04040402);
    wr(ADDR_THRESH, 32'h000C0404);
    wr(ADDR_RLEN, 32'h00000040);
    lim = 28;
    wr(ADDR_TAIL, 32'h00000038);
    for (i = 0; i < 6 && fetch_req !== 1'b1; i++) @(negedge clk);
    chk(fetch_req === 1'b1, "empty store did not fetch");
    // Random traffic, prompt and slow host
    for (int k = 0; k < 12; k++) begin
      slow = k[2];
      pkt(1'($urandom_range(0, 1)));
    end
    // Parsing off then on, frame check bytes kept
    wr(ADDR_CTRL, 32'h00000003);
    {parse, strip} = 2'b00;
    repeat (4) pkt(1'b0);
    wr(ADDR_CTRL, 32'h0000000B);
    parse = 1;
    repeat (4) pkt(1'b0);
    drain();
    // Partial line waits, then software flush
    repeat (2) pkt(1'b0);
    rd(ADDR_STAT, 32'h0000FF00, 32'h00000200);
    wr(ADDR_PDT, 32'h80000000);
    drain();
    rd(ADDR_PDT, 32'h80000000, 32'h00000000);
    // Timer expiry flushes, then interrupt
    repeat (2) pkt(1'b0);
    @(posedge clk);
    timer_expired <= 1'b1;
    @(posedge clk);
    timer_expired <= 1'b0;
    for (i = 0; i < 80 && !irq_seen; i++) @(negedge clk);
    chk(irq_seen, "no interrupt after expiry");
    // Unaligned write-back threshold
    wr(ADDR_THRESH, 32'h00020404);
    repeat (2) pkt(1'b0);
    drain();
    rd(ADDR_HEAD, 32'h0000FFFF, 32'(hd));
    // Legacy format: null descriptors pad
    wr(ADDR_CTRL, 32'h00000009);
    split_m = 0;
    lim = 56;
    repeat (2) pkt(1'b1);
    drain();
    wrap_up();
  end
endmodule
